// ---- design/ocw_params.svh ----
// named constants for the output compare watchdog
`ifndef OCW_PARAMS_SVH
`define OCW_PARAMS_SVH

`define OCW_OUT_W        8            // width of the user logic output bus
`define OCW_IN_W         8            // width of the user logic input data
`define OCW_WD_W         32           // width of the watchdog counter
`define OCW_WD_TC_DEF    32'd1000000  // default terminal count, in enabled cycles
`define OCW_WD_ZERO      32'h00000000 // watchdog counter cleared value
`define OCW_WD_ONE       32'h00000001 // watchdog counter step
`define OCW_STATUS_LEVEL 1'b0         // level driven on the always-low status pin
`define OCW_ACC_ZERO     8'h00        // user logic accumulator reset value

`endif

// ---- design/ocw_pkg.sv ----
// types shared by the output compare watchdog design
`include "ocw_params.svh"

package ocw_pkg;

    // user logic input word
    typedef struct packed {
        logic                 valid;  // take data this cycle
        logic [`OCW_IN_W-1:0] data;   // value to accumulate
    } ocw_user_in_t;

    // global control lines of the device
    typedef struct packed {
        logic set_reset;  // global_set_reset_line
        logic out_float;  // global_output_float
    } ocw_glob_t;

    // watchdog states, gray coded along online -> timing -> fire
    typedef enum logic [1:0] {
        OCW_ST_ONLINE = 2'h0,
        OCW_ST_TIMING = 2'h1,
        OCW_ST_FIRE   = 2'h3
    } ocw_wd_state_t;

endpackage

// ---- design/ocw_top.sv ----
// output compare watchdog: duplicated logic, output float and neighbour watchdog
//
// Functional notes
// - two logic copies, XOR per output pair
// - float control is OR of mismatches, reset
// - float control puts every user output and the status pin high impedance
// - reset and float paths purely combinational
// - no mismatch, no reset: outputs keep driving
// - watchdog enable is neighbour status pin
// - count each clock while neighbour status high; the clock of the pulse cycle is not counted
// - terminal count pulses reset in both devices
// - terminal count is a design parameter
// - status falling edge pulses reset in both
`timescale 1ns/10ps
`include "ocw_params.svh"

module ocw_top
    import ocw_pkg::*;
#(
    // enabled cycles from neighbour going off-line to the reset pulse
    parameter logic [`OCW_WD_W-1:0] WD_TERMINAL = `OCW_WD_TC_DEF
)
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // user data into both logic copies
    input  wire ocw_user_in_t          user_in,
    // user output pins, three-signal form
    output logic [`OCW_OUT_W-1:0]      pin_out,
    output logic [`OCW_OUT_W-1:0]      pin_oe,
    // own always-low status pin, three-signal form
    output logic                       status_out,
    output logic                       status_oe,
    // neighbour always-low status pin, high when it floats
    input  wire logic                  nbr_status_in,
    // shared global reset line between the two devices
    input  wire logic                  nbr_reset_in,
    output logic                       nbr_reset_out,
    // global lines, visible for observation
    output ocw_glob_t                  glob
);

    logic [`OCW_OUT_W-1:0] copy_a;    // main copy outputs (registered)
    logic [`OCW_OUT_W-1:0] copy_b;    // duplicate copy outputs (registered)
    logic [`OCW_OUT_W-1:0] mismatch;  // one flag per output pair
    logic                  reset_line; // global_set_reset_line
    logic                  float_line; // global_output_float
    logic                  wd_pulse;  // watchdog reset pulse
    logic                  fall_pulse_q; // neighbour back-online pulse
    logic                  fall_pulse_d;
    logic                  nbr_prev_q;   // last sampled neighbour status
    logic                  nbr_prev_d;
    ocw_wd_state_t         state_q;   // watchdog state
    ocw_wd_state_t         state_d;
    logic [`OCW_WD_W-1:0]  cnt_q;     // watchdog count of off-line cycles
    logic [`OCW_WD_W-1:0]  cnt_d;
    logic                  at_term;   // counter one short of terminal count

    // main copy of the user logic
    ocw_user_logic u_copy_a
    (
        .core_clk (core_clk),
        .glob_rst (reset_line),
        .user_in  (user_in),
        .acc_q    (copy_a)
    );

    // duplicate copy, fed identically
    ocw_user_logic u_copy_b
    (
        .core_clk (core_clk),
        .glob_rst (reset_line),
        .user_in  (user_in),
        .acc_q    (copy_b)
    );

    // per-bit compare and pin drive
    genvar gi;
    generate
        for (gi = 0; gi < `OCW_OUT_W; gi++)
        begin : g_pair
            // exclusive-or of each output pair
            assign mismatch[gi] = copy_a[gi] ^ copy_b[gi];
            // data from the main copy flop
            assign pin_out[gi] = copy_a[gi];
            // drive only while the float line is low
            assign pin_oe[gi] = ~float_line;
        end
    endgenerate

    // global reset: system reset, own pulses, neighbour pulses; no storage
    assign reset_line = sys_rst | wd_pulse | fall_pulse_q | nbr_reset_in;

    // float: any mismatch or the reset line itself, so a broken reset gate still floats
    assign float_line = (|mismatch) | reset_line;

    // own status pin: constant low, floats with the other outputs
    assign status_out = `OCW_STATUS_LEVEL;
    assign status_oe  = ~float_line;

    // pulses reach the neighbour over the shared line
    assign nbr_reset_out = wd_pulse | fall_pulse_q;

    // global lines bundled for observation
    assign glob.set_reset = reset_line;
    assign glob.out_float = float_line;

    // watchdog pulse comes straight from the state register
    assign wd_pulse = (state_q == OCW_ST_FIRE);

    // terminal count reached on this enabled cycle
    assign at_term = (cnt_q == (WD_TERMINAL - `OCW_WD_ONE));

    // falling edge detector on the neighbour status
    always_comb
    begin
        nbr_prev_d   = nbr_status_in;
        fall_pulse_d = nbr_prev_q & ~nbr_status_in;
    end

    // register edge detector
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            nbr_prev_q   <= 1'b0;
            fall_pulse_q <= 1'b0;
        end
        else
        begin
            nbr_prev_q   <= nbr_prev_d;
            fall_pulse_q <= fall_pulse_d;
        end
    end

    // watchdog next state and count
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            // neighbour on-line: counter held at zero
            OCW_ST_ONLINE:
            begin
                cnt_d = `OCW_WD_ZERO;
                if (nbr_status_in)
                begin
                    // first enabled cycle counts already
                    if (WD_TERMINAL == `OCW_WD_ONE)
                    begin
                        state_d = OCW_ST_FIRE;
                    end
                    else
                    begin
                        state_d = OCW_ST_TIMING;
                        cnt_d   = `OCW_WD_ONE;
                    end
                end
            end
            // neighbour off-line: count enabled cycles
            OCW_ST_TIMING:
            begin
                if (!nbr_status_in)
                begin
                    state_d = OCW_ST_ONLINE;
                    cnt_d   = `OCW_WD_ZERO;
                end
                else if (at_term)
                begin
                    state_d = OCW_ST_FIRE;
                    cnt_d   = `OCW_WD_ZERO;
                end
                else
                begin
                    cnt_d = cnt_q + `OCW_WD_ONE;
                end
            end
            // one-cycle pulse, counter restarts from zero
            OCW_ST_FIRE:
            begin
                cnt_d   = `OCW_WD_ZERO;
                state_d = OCW_ST_ONLINE;
            end
            // unused code: recover
            default:
            begin
                state_d = OCW_ST_ONLINE;
                cnt_d   = `OCW_WD_ZERO;
            end
        endcase
    end

    // register watchdog
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_q <= OCW_ST_ONLINE;
            cnt_q   <= `OCW_WD_ZERO;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // checks, all on the core clock
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // neighbour status falls
    sequence s_nbr_fall;
        nbr_status_in ##1 !nbr_status_in;
    endsequence

    // counter sitting one short of terminal while enabled
    sequence s_wd_term;
        state_q == OCW_ST_TIMING && nbr_status_in && at_term;
    endsequence

    chk_mismatch_xor: assert property ((copy_a != copy_b) |-> (|mismatch) && float_line)
        else $error("copy difference raised no mismatch flag");

    // float from its independent causes, not from the internal or terms
    chk_float_cause: assert property (float_line ==
        ((copy_a != copy_b) || nbr_reset_in || wd_pulse || fall_pulse_q))
        else $error("float line not the or of mismatches and reset");

    chk_pins_float: assert property (float_line |-> (pin_oe == '0) && !status_oe)
        else $error("an output still drives while floated");

    chk_pins_drive: assert property (!float_line |-> (&pin_oe) && status_oe)
        else $error("outputs not driving without fault");

    chk_async_reset: assert property ((wd_pulse || fall_pulse_q) |->
        reset_line && float_line && nbr_reset_out)
        else $error("pulse did not reach global lines at once");

    chk_count_step: assert property (state_q == OCW_ST_TIMING && nbr_status_in && !at_term
        |=> cnt_q == $past(cnt_q) + `OCW_WD_ONE)
        else $error("watchdog did not count an enabled cycle");

    chk_count_clear: assert property (!nbr_status_in |=> cnt_q == `OCW_WD_ZERO)
        else $error("watchdog not cleared while neighbour on-line");

    chk_fire_term: assert property (s_wd_term |=> wd_pulse && nbr_reset_out
        ##1 !wd_pulse && cnt_q == `OCW_WD_ZERO)
        else $error("terminal count pulse wrong");

    chk_edge_pulse: assert property (s_nbr_fall |=>
        fall_pulse_q && reset_line && nbr_reset_out)
        else $error("no reset pulse on neighbour back on-line");

endmodule

// ---- design/ocw_user_logic.sv ----
// one copy of the duplicated user logic: a registered accumulator
`timescale 1ns/10ps
`include "ocw_params.svh"

module ocw_user_logic
    import ocw_pkg::*;
(
    // clock and global reset
    input  wire logic                  core_clk,
    input  wire logic                  glob_rst,
    // user data
    input  wire ocw_user_in_t          user_in,
    output logic [`OCW_OUT_W-1:0]      acc_q
);

    logic [`OCW_OUT_W-1:0] acc_d;  // next accumulator value

    // add the input word when valid, clear on the global reset
    always_comb
    begin
        acc_d = acc_q;
        if (glob_rst)
        begin
            acc_d = `OCW_ACC_ZERO;
        end
        else if (user_in.valid)
        begin
            acc_d = acc_q + user_in.data;
        end
    end

    // register only
    always_ff @(posedge core_clk)
    begin
        acc_q <= acc_d;
    end

endmodule

// ---- sim/ocw_nbr_model.sv ----
// behavioural neighbour device: always-low status pin and reset pulse
`timescale 1ns/10ps

module ocw_nbr_model
(
    // clock
    input  wire logic core_clk,
    // bench commands
    input  wire logic offline,
    input  wire logic rst_cmd,
    // far-side lines
    output wire       nbr_status,
    output logic      nbr_reset
);
    // pin floats while off-line, the pull-up lifts it; online drives low
    assign nbr_status = offline ? 1'bz : 1'b0;
    pullup (nbr_status);

    // reset pulse launched just after the edge, one cycle per command
    always_ff @(posedge core_clk)
    begin
        nbr_reset <= rst_cmd;
    end
endmodule

// ---- sim/output_compare_watchdog_test.sv ----
// self-checking bench for the output compare watchdog
`timescale 1ns/10ps
`include "ocw_params.svh"

module output_compare_watchdog_test
    import ocw_pkg::*;
;
    localparam int WD_T = 4;          // short terminal count for simulation
    logic                 core_clk;   // 4 ns clock
    logic                 sys_rst;    // synchronous reset
    ocw_user_in_t         user_in;    // data into both copies
    logic [`OCW_OUT_W-1:0] pin_out;   // pin data
    logic [`OCW_OUT_W-1:0] pin_oe;    // pin enables
    logic [`OCW_OUT_W-1:0] pin_w;     // resolved pin level
    logic                 status_out; // own status data
    logic                 status_oe;  // own status enable
    wire                  nbr_status; // neighbour status line
    logic                 nbr_rst;    // neighbour reset pulse
    logic                 nbr_reset_out;
    ocw_glob_t            glob;       // global lines
    logic                 offline;    // neighbour off-line command
    logic                 rst_cmd;    // neighbour reset command
    int                   n_fail;     // mismatches
    int                   checks;     // comparisons

    // device under test
    ocw_top #(.WD_TERMINAL(WD_T)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .user_in(user_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .status_out(status_out),
        .status_oe(status_oe), .nbr_status_in(nbr_status),
        .nbr_reset_in(nbr_rst), .nbr_reset_out(nbr_reset_out), .glob(glob));

    // neighbour device
    ocw_nbr_model nbr (.core_clk(core_clk), .offline(offline),
        .rst_cmd(rst_cmd), .nbr_status(nbr_status), .nbr_reset(nbr_rst));

    // pin level from data and enable
    always_comb
    begin
        for (int i = 0; i < `OCW_OUT_W; i++)
            pin_w[i] = pin_oe[i] ? pin_out[i] : 1'bz;
    end

    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one cycle, ending at the falling edge
    task automatic tick;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // global lines and pin float as a group
    task automatic glob_chk(input logic on);
        check(glob.set_reset, on);
        check(glob.out_float, on);
        check(pin_oe, on ? 8'h00 : 8'hff);
        check(status_oe, !on);
        if (on)
            check(pin_w, 8'hzz);
    endtask

    // watchdog pulse plus globals
    task automatic wd_chk(input logic on);
        check(nbr_reset_out, on);
        glob_chk(on);
    endtask

    // quiet cycles, then one pulse cycle
    task automatic wd_run(input int quiet);
        repeat (quiet)
        begin
            tick();
            wd_chk(1'b0);
        end
        tick();
        wd_chk(1'b1);
    endtask

    // outputs drive zero after reset
    task automatic t_reset;
        check(pin_out, 8'h00);
        check(status_out, `OCW_STATUS_LEVEL);
        glob_chk(1'b0);
    endtask

    // both copies accumulate alike, no float
    task automatic t_accum;
        logic [7:0] sum;
        sum = 8'h00;
        foreach (sum[i])
        begin
            user_in = '{1'b1, 8'h1f << i};
            sum = sum + (8'h1f << i);
            tick();
        end
        user_in = '{1'b0, 8'hff};
        tick();
        check(pin_out, sum);
        glob_chk(1'b0);
    endtask

    // neighbour reset floats pins at once, clears copies
    task automatic t_nbr_rst;
        rst_cmd = 1'b1;
        tick();
        glob_chk(1'b1);
        check(nbr_reset_out, 1'b0);
        rst_cmd = 1'b0;
        tick();
        glob_chk(1'b0);
        check(pin_out, 8'h00);
    endtask

    // long outage: pulse, restart, pulse, back online
    task automatic t_watchdog;
        offline = 1'b1;
        wd_run(WD_T - 1);
        wd_run(WD_T);
        offline = 1'b0;
        tick();
        wd_chk(1'b1);
        tick();
        wd_chk(1'b0);
    endtask

    // short outages never reach terminal count
    task automatic t_short;
        repeat (2)
        begin
            offline = 1'b1;
            repeat (WD_T - 1)
            begin
                tick();
                wd_chk(1'b0);
            end
            offline = 1'b0;
            tick();
            wd_chk(1'b1);
            tick();
            wd_chk(1'b0);
        end
    endtask

    // counts, verdict, end of run
    task automatic print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #10000;
        n_fail++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        n_fail = 0;
        checks = 0;
        sys_rst = 1'b1;
        user_in = '{1'b0, 8'h00};
        offline = 1'b0;
        rst_cmd = 1'b0;
        repeat (5) @(negedge core_clk);
        glob_chk(1'b1);
        sys_rst = 1'b0;
        tick();
        t_reset();
        t_accum();
        t_nbr_rst();
        t_watchdog();
        t_short();
        print_verdict();
    end
endmodule
